//--- src/sfl_defs.svh
`ifndef SFL_DEFS_SVH
`define SFL_DEFS_SVH
// system clock and link clock divider
`define SFL_CLK_MHZ 20
`define SFL_SCK_HALF 4'd2
`define SFL_DIV_W 4
// reset pin timing, microseconds, and derived cycle counts
`define SFL_T_RST_US 10
`define SFL_T_REC_US 1
`define SFL_RST_CYC (`SFL_T_RST_US * `SFL_CLK_MHZ)
`define SFL_REC_CYC (`SFL_T_REC_US * `SFL_CLK_MHZ)
// worst-case busy times of the memory, plus the typical OTP program time
`define SFL_T_EP_MS 25
`define SFL_T_P_MS 3
`define SFL_T_OTPP_US 500
`define SFL_T_OTPP_TYP_US 200
`define SFL_EP_CYC (`SFL_T_EP_MS * 1000 * `SFL_CLK_MHZ)
`define SFL_P_CYC (`SFL_T_P_MS * 1000 * `SFL_CLK_MHZ)
`define SFL_OTPP_CYC (`SFL_T_OTPP_US * `SFL_CLK_MHZ)
`define SFL_TMR_W 19
// page refresh bookkeeping
`define SFL_REWRITE_LIMIT 50000
`define SFL_REWRITE_EVERY 16'd16
`define SFL_PAGES 11'd2047
`define SFL_PTR_W 11
`define SFL_PAGE_SHIFT 9
// opcodes the host treats as reads
`define SFL_OP_ARRAY_RD_LP 8'h01
`define SFL_OP_ARRAY_RD 8'h03
`define SFL_OP_BUF1_RD 8'hd1
`define SFL_OP_BUF2_RD 8'hd3
`define SFL_OP_PROT_RD 8'h32
`define SFL_OP_LOCK_RD 8'h35
`define SFL_OP_SEC_RD 8'h77
`define SFL_OP_STATUS_RD 8'hd7
`endif

//--- src/sfl_pkg.sv
package sfl_pkg;
   typedef enum logic [2:0] {
      ST_BOOT  = 3'h0,
      ST_RHOLD = 3'h1,
      ST_WAIT  = 3'h2,
      ST_IDLE  = 3'h3,
      ST_SETUP = 3'h4,
      ST_SHIFT = 3'h5,
      ST_TAIL  = 3'h6
   } sfl_state_t;

   // what the memory does after the frame, and so how long to wait
   typedef enum logic [1:0] {
      KIND_READ = 2'h0,
      KIND_PROG = 2'h1,
      KIND_EP   = 2'h2,
      KIND_OTP  = 2'h3
   } sfl_kind_t;
endpackage

//--- src/sfl_tmr_if.sv
`timescale 1ns/100ps
`default_nettype none
`include "sfl_defs.svh"
interface sfl_tmr_if;
   logic                   start;
   logic [`SFL_TMR_W-1:0]  load;
   logic                   done;
   modport ctl (output start, output load, input done);
   modport tmr (input start, input load, output done);
endinterface
`default_nettype wire

//--- src/sfl_sync2.sv
`timescale 1ns/100ps
`default_nettype none
module sfl_sync2 (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic d,
   output logic      q
);
   logic meta_r;

   // two stages; only the second stage is ever read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= 1'b0;
         q      <= 1'b0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule
`default_nettype wire

//--- src/sfl_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "sfl_defs.svh"
module sfl_timer (
   input  wire logic clk,
   input  wire logic rst_n,
   sfl_tmr_if.tmr    t
);
   logic [`SFL_TMR_W-1:0] cnt_r;

   // down counter; start reloads even while running
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
      end else if (t.start) begin
         cnt_r <= t.load;
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

   assign t.done = (cnt_r == '0);
endmodule
`default_nettype wire

//--- src/sfl_host.sv
`timescale 1ns/100ps
`default_nettype none
`include "sfl_defs.svh"
module sfl_host
   import sfl_pkg::*;
#(
   parameter int         EP_CYC     = `SFL_EP_CYC,
   parameter int         P_CYC      = `SFL_P_CYC,
   parameter int         OTPP_CYC   = `SFL_OTPP_CYC,
   parameter logic [7:0] REWRITE_OP = 8'h00
) (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  cmd_valid,
   output logic                       cmd_ready,
   input  wire logic [7:0]            cmd_op,
   input  wire logic [23:0]           cmd_addr,
   input  wire logic [1:0]            cmd_addr_bytes,
   input  wire logic [2:0]            cmd_dummy_bytes,
   input  wire logic [9:0]            cmd_len,
   input  wire sfl_kind_t             cmd_kind,
   input  wire logic [7:0]            wr_data,
   input  wire logic                  wr_valid,
   output logic                       wr_ready,
   output logic [7:0]                 rd_data,
   output logic                       rd_valid,
   output logic                       busy,
   output logic [`SFL_PTR_W-1:0]      rewrite_ptr,
   output logic                       sck,
   output logic                       cs_n,
   output logic                       mosi,
   output logic                       flash_rst_n,
   input  wire logic                  miso
);
   sfl_state_t              state_r;
   sfl_state_t              state_nxt;
   sfl_kind_t               kind_r;
   logic [`SFL_DIV_W-1:0]   div_r;
   logic [15:0]             j_r;
   logic [15:0]             tx_bits_r;
   logic [15:0]             rx_bits_r;
   logic [3:0]              hdr_r;
   logic [1:0]              ab_r;
   logic [7:0]              op_r;
   logic [23:0]             asr_r;
   logic [7:0]              txs_r;
   logic [7:0]              rxs_r;
   logic [2:0]              rb_r;
   logic                    rd_r;
   logic                    own_r;
   logic                    rw_pend_r;
   logic [15:0]             ops_r;
   logic                    miso_s;
   logic                    tick;
   logic                    rise;
   logic                    fall;
   logic                    need_wr;
   logic                    stall;
   logic                    launch;
   logic                    end_frame;
   logic                    last_fall;
   logic                    rx_take;
   logic [12:0]             bi;
   logic [7:0]              tx_new;
   logic [15:0]             ln_bits;
   logic                    cmd_rd;
   sfl_tmr_if tm ();
   sfl_timer u_timer (
      .clk   (clk),
      .rst_n (rst_n),
      .t     (tm)
   );

   // miso comes from the pin, so it is retimed before anything looks at it
   sfl_sync2 u_miso_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (miso),
      .q     (miso_s)
   );

   // read opcodes decide whether the data phase is sent or received
   function automatic logic is_rd(input logic [7:0] op);
      return (op == `SFL_OP_ARRAY_RD_LP) || (op == `SFL_OP_ARRAY_RD)
             || (op == `SFL_OP_BUF1_RD) || (op == `SFL_OP_BUF2_RD)
             || (op == `SFL_OP_PROT_RD) || (op == `SFL_OP_LOCK_RD)
             || (op == `SFL_OP_SEC_RD)
             || (op == `SFL_OP_STATUS_RD);
   endfunction

   // frame event strobes; sck is made here, so it is no second domain
   assign tick      = (div_r == '0);
   assign bi        = j_r[15:3];
   assign need_wr   = (state_r == ST_SHIFT) && tick && !sck && (j_r < tx_bits_r)
                      && (j_r[2:0] == 3'h0) && (bi >= 13'(hdr_r));
   assign stall     = need_wr && !wr_valid;
   assign rise      = (state_r == ST_SHIFT) && tick && !sck && !stall;
   assign fall      = (state_r == ST_SHIFT) && tick && sck;
   assign last_fall = fall && (j_r == tx_bits_r + rx_bits_r + 16'd1);
   assign rx_take   = fall && (j_r >= tx_bits_r + 16'd2);
   assign launch    = (state_r == ST_IDLE) && (rw_pend_r || cmd_valid);
   assign end_frame = (state_r == ST_TAIL) && tick;
   assign cmd_ready = (state_r == ST_IDLE) && !rw_pend_r;
   assign wr_ready  = need_wr; // a byte is taken when wr_ready and wr_valid
   assign busy      = (state_r != ST_IDLE);
   assign cmd_rd    = is_rd(cmd_op);
   assign ln_bits   = {3'h0, cmd_len, 3'h0};

   // byte placed on mosi at a byte boundary: opcode, address, dummies, data
   always_comb begin
      if (bi == 13'h0) begin
         tx_new = op_r;
      end else if (bi <= 13'(ab_r)) begin
         tx_new = asr_r[23:16];
      end else if (bi < 13'(hdr_r)) begin
         tx_new = 8'h00;
      end else begin
         tx_new = wr_data;
      end
   end

   // state sequencing: pin reset, recovery, idle, frame, busy wait
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_BOOT:  state_nxt = ST_RHOLD;
         ST_RHOLD: if (tm.done) state_nxt = ST_WAIT;
         ST_WAIT:  if (tm.done) state_nxt = ST_IDLE;
         ST_IDLE:  if (launch) state_nxt = ST_SETUP;
         ST_SETUP: if (tick) state_nxt = ST_SHIFT;
         ST_SHIFT: if (last_fall) state_nxt = ST_TAIL;
         ST_TAIL:  if (tick) state_nxt = (kind_r == KIND_READ) ? ST_IDLE : ST_WAIT;
         default:  state_nxt = ST_BOOT;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_BOOT;
      end else begin
         state_r <= state_nxt;
      end
   end

   // timer loads: reset pulse, recovery, then worst-case busy per kind
   always_comb begin
      tm.start = 1'b0;
      tm.load  = '0;
      if (state_r == ST_BOOT) begin
         tm.start = 1'b1;
         tm.load  = `SFL_TMR_W'(`SFL_RST_CYC);
      end else if (state_r == ST_RHOLD && tm.done) begin
         tm.start = 1'b1;
         tm.load  = `SFL_TMR_W'(`SFL_REC_CYC);
      end else if (end_frame && kind_r != KIND_READ) begin
         tm.start = 1'b1;
         tm.load  = (kind_r == KIND_EP)   ? `SFL_TMR_W'(EP_CYC) :
                    (kind_r == KIND_PROG) ? `SFL_TMR_W'(P_CYC) :
                                            `SFL_TMR_W'(OTPP_CYC);
      end
   end

   // memory reset pin; chip select is already high from reset onward
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flash_rst_n <= 1'b0;
      end else if (state_r == ST_RHOLD && tm.done && cs_n) begin
         flash_rst_n <= 1'b1;
      end
   end

   // command capture; a due refresh goes ahead of user commands
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         op_r      <= 8'h00;
         asr_r     <= 24'h000000;
         ab_r      <= 2'h0;
         hdr_r     <= 4'h1;
         kind_r    <= KIND_READ;
         rd_r      <= 1'b0;
         own_r     <= 1'b0;
         tx_bits_r <= 16'h0000;
         rx_bits_r <= 16'h0000;
      end else if (launch && rw_pend_r) begin
         op_r      <= REWRITE_OP;
         asr_r     <= 24'(rewrite_ptr) << `SFL_PAGE_SHIFT;
         ab_r      <= 2'h3;
         hdr_r     <= 4'h4;
         kind_r    <= KIND_EP;
         rd_r      <= 1'b0;
         own_r     <= 1'b1;
         tx_bits_r <= 16'h0020;
         rx_bits_r <= 16'h0000;
      end else if (launch) begin
         op_r      <= cmd_op;
         asr_r     <= cmd_addr << (5'd8 * (5'd3 - 5'(cmd_addr_bytes)));
         ab_r      <= cmd_addr_bytes;
         hdr_r     <= 4'd1 + 4'(cmd_addr_bytes) + 4'(cmd_dummy_bytes);
         kind_r    <= cmd_kind; // direct or buffered page writes both fit
         rd_r      <= cmd_rd;
         own_r     <= 1'b0;
         tx_bits_r <= {9'h0, 4'd1 + 4'(cmd_addr_bytes) + 4'(cmd_dummy_bytes), 3'h0}
                      + (cmd_rd ? 16'h0000 : ln_bits);
         rx_bits_r <= cmd_rd ? ln_bits : 16'h0000;
      end else if (rise && j_r[2:0] == 3'h0 && bi != 13'h0 && bi <= 13'(ab_r)) begin
         asr_r <= {asr_r[15:0], 8'h00};
      end
   end

   // half-period divider; it waits at zero while the data byte is late
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_r <= `SFL_SCK_HALF - 4'd1;
      end else if (state_r == ST_SETUP || state_r == ST_SHIFT || state_r == ST_TAIL) begin
         if (!tick) begin
            div_r <= div_r - 4'd1;
         end else if (!stall) begin
            div_r <= `SFL_SCK_HALF - 4'd1;
         end
      end else begin
         div_r <= `SFL_SCK_HALF - 4'd1;
      end
   end

   // sck idles low, which is mode 0; a stall stretches the low phase only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sck <= 1'b0;
      end else if (rise) begin
         sck <= 1'b1;
      end else if (fall) begin
         sck <= 1'b0;
      end
   end

   // chip select low around the frame, high again once the tail half passes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_n <= 1'b1;
      end else if (launch) begin
         cs_n <= 1'b0;
      end else if (end_frame) begin
         cs_n <= 1'b1;
      end
   end

   // rise counter; one extra rise lets the memory take the last bit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         j_r <= 16'h0000;
      end else if (launch) begin
         j_r <= 16'h0000;
      end else if (rise) begin
         j_r <= j_r + 16'd1;
      end
   end

   // mosi changes only with sck rising, a full period before the memory samples
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mosi  <= 1'b0;
         txs_r <= 8'h00;
      end else if (launch) begin
         mosi  <= 1'b0;
      end else if (rise) begin
         if (j_r >= tx_bits_r) begin
            mosi <= 1'b0;
         end else if (j_r[2:0] == 3'h0) begin
            mosi  <= tx_new[7];
            txs_r <= {tx_new[6:0], 1'b0};
         end else begin
            mosi  <= txs_r[7];
            txs_r <= {txs_r[6:0], 1'b0};
         end
      end
   end

   // capture miso at the fall after the one that launched the bit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rxs_r    <= 8'h00;
         rb_r     <= 3'h0;
         rd_data  <= 8'h00;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= 1'b0;
         if (launch) begin
            rb_r <= 3'h0;
         end else if (rx_take && rd_r) begin
            rxs_r <= {rxs_r[6:0], miso_s};
            rb_r  <= rb_r + 3'h1;
            if (rb_r == 3'h7) begin
               rd_data  <= {rxs_r[6:0], miso_s};
               rd_valid <= 1'b1;
            end
         end
      end
   end

   // refresh pacing: one page every few erase-program ops keeps each far under the limit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ops_r       <= 16'h0000;
         rw_pend_r   <= 1'b0;
         rewrite_ptr <= '0;
      end else if (launch && rw_pend_r) begin
         rw_pend_r <= 1'b0;
         rewrite_ptr <= (rewrite_ptr == `SFL_PAGES) ? '0 : rewrite_ptr + 1'b1;
      end else if (end_frame && !own_r && (kind_r == KIND_EP || kind_r == KIND_PROG)) begin
         if (ops_r == `SFL_REWRITE_EVERY - 16'd1) begin
            ops_r     <= 16'h0000;
            rw_pend_r <= 1'b1;
         end else begin
            ops_r <= ops_r + 16'd1;
         end
      end
   end
endmodule
`default_nettype wire

//--- dv/sfl_host_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "sfl_defs.svh"
module sfl_host_chk
   import sfl_pkg::*;
#(
   parameter int EP_CYC   = 50,
   parameter int P_CYC    = 20,
   parameter int OTPP_CYC = 10
) (
   input wire logic                  clk,
   input wire logic                  rst_n,
   input wire logic                  cmd_valid,
   input wire logic                  cmd_ready,
   input wire sfl_kind_t             cmd_kind,
   input wire logic                  rd_valid,
   input wire logic                  busy,
   input wire logic [`SFL_PTR_W-1:0] rewrite_ptr,
   input wire logic                  sck,
   input wire logic                  cs_n,
   input wire logic                  mosi,
   input wire logic                  flash_rst_n
);
   int   need_r;
   int   cnt_r;
   logic take_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // wait owed by the last frame; -1 until one was seen, so the boot wait is not judged
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         take_r <= 1'b0;
         need_r <= -1;
      end else begin
         take_r <= cmd_valid && cmd_ready;
         if (cmd_valid && cmd_ready) begin
            case (cmd_kind)
               KIND_PROG: need_r <= P_CYC;
               KIND_EP:   need_r <= EP_CYC;
               KIND_OTP:  need_r <= OTPP_CYC;
               default:   need_r <= 0;
            endcase
         end else if ($fell(cs_n) && !take_r) begin
            need_r <= EP_CYC; // refresh frame, no user request behind it
         end
      end
   end

   // busy cycles since chip select went high
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) cnt_r <= 0;
      else if (!cs_n) cnt_r <= 0;
      else if (busy) cnt_r <= cnt_r + 1;
   end

   // setup state plus one low half: sck rises four cycles after select
   sequence s_lead;
      !sck [*4] ##1 sck;
   endsequence
   sequence s_high;
      sck [*2] ##1 !sck;
   endsequence

   property p_rst_order;
      $rose(flash_rst_n) |-> cs_n && $past(cs_n);
   endproperty
   property p_rst_cs;
      !flash_rst_n |-> cs_n;
   endproperty
   property p_idle_low;
      cs_n |-> !sck;
   endproperty
   property p_lead;
      $fell(cs_n) |-> s_lead;
   endproperty
   property p_high;
      $rose(sck) |-> s_high;
   endproperty
   property p_mosi_high;
      (sck && !$rose(sck)) |-> $stable(mosi);
   endproperty
   property p_mosi_fall;
      $fell(sck) |-> $stable(mosi);
   endproperty
   property p_capture;
      rd_valid |-> !sck && $past(sck) ##1 !rd_valid;
   endproperty
   property p_wait;
      ($fell(busy) && need_r >= 0) |-> cnt_r >= need_r - 1 && cnt_r <= need_r + 4;
   endproperty
   property p_ptr;
      $changed(rewrite_ptr) |-> busy && rewrite_ptr == $past(rewrite_ptr) + 11'h1;
   endproperty

   a_rst_order: assert property (p_rst_order) else $error("cs_n low at memory reset release");
   a_rst_cs: assert property (p_rst_cs) else $error("cs_n low during memory reset");
   a_idle_low: assert property (p_idle_low) else $error("sck not low while deselected");
   a_lead: assert property (p_lead) else $error("first rise not four cycles after select");
   a_high: assert property (p_high) else $error("sck high phase not two cycles");
   a_mosi_high: assert property (p_mosi_high) else $error("mosi moved in high phase");
   a_mosi_fall: assert property (p_mosi_fall) else $error("mosi moved at falling sck");
   a_capture: assert property (p_capture) else $error("read byte not after a fall");
   a_wait: assert property (p_wait) else $error("busy wait length wrong");
   a_ptr: assert property (p_ptr) else $error("refresh pointer step wrong");
endmodule

bind sfl_host sfl_host_chk #(.EP_CYC(EP_CYC), .P_CYC(P_CYC), .OTPP_CYC(OTPP_CYC)) chk_u (
   .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
   .cmd_kind(cmd_kind), .rd_valid(rd_valid), .busy(busy), .rewrite_ptr(rewrite_ptr),
   .sck(sck), .cs_n(cs_n), .mosi(mosi), .flash_rst_n(flash_rst_n));
`default_nettype wire

//--- dv/sfl_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "sfl_defs.svh"
module sfl_mem_model (
   input  wire logic   sck,
   input  wire logic   cs_n,
   input  wire logic   mosi,
   input  wire logic   flash_rst_n,
   output logic        miso,
   output logic [47:0] hdr,
   output logic        fault
);
   logic mosi_q;
   int   rise_r;
   int   obit_r;
   logic [7:0] b;

   function automatic logic is_rd(input logic [7:0] op);
      return op inside {`SFL_OP_ARRAY_RD_LP, `SFL_OP_ARRAY_RD, `SFL_OP_BUF1_RD,
                        `SFL_OP_BUF2_RD, `SFL_OP_PROT_RD, `SFL_OP_LOCK_RD,
                        `SFL_OP_SEC_RD, `SFL_OP_STATUS_RD};
   endfunction

   initial begin
      miso = 1'b0;
      fault = 1'b0;
      hdr = '0;
   end
   // latched mid-period, so a rise sees the bit launched one period earlier
   always @(negedge sck) mosi_q <= mosi;
   always @(negedge cs_n) begin
      rise_r = 0;
      obit_r = 0;
      hdr = '0;
   end
   // first 48 bits taken in on rises; rise 1 carries nothing yet
   always @(posedge sck) if (!cs_n) begin
      if (rise_r >= 1 && rise_r <= 48) hdr[48-rise_r] = mosi_q;
      rise_r = rise_r + 1;
   end
   // reply stream from the fall after the opcode: byte n is opcode xor n
   always @(negedge sck or posedge cs_n) begin
      if (cs_n) miso <= ~miso;
      else if (rise_r >= 9 && is_rd(hdr[47:40])) begin
         b = hdr[47:40] ^ 8'(obit_r / 8);
         miso <= b[7 - obit_r % 8];
         obit_r = obit_r + 1;
      end else miso <= ~miso; // nothing to say: the line keeps moving
   end
   // select must already be high when the reset pin is let go
   always @(posedge flash_rst_n) if (cs_n !== 1'b1) fault <= 1'b1;
endmodule
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "sfl_defs.svh"
module testbench
   import sfl_pkg::*;
;
   localparam logic [7:0] RW_OP = 8'h58; // arbitrary rewrite opcode
   localparam logic [7:0] RD_OPS [8] = '{`SFL_OP_ARRAY_RD_LP, `SFL_OP_ARRAY_RD,
      `SFL_OP_BUF1_RD, `SFL_OP_BUF2_RD, `SFL_OP_PROT_RD, `SFL_OP_LOCK_RD,
      `SFL_OP_SEC_RD, `SFL_OP_STATUS_RD};
   logic clk, rst_n, cmd_valid, cmd_ready, wr_valid, wr_ready, rd_valid, busy;
   logic sck, cs_n, mosi, flash_rst_n, miso, mem_fault, wtake;
   logic [7:0]  cmd_op, wr_data, rd_data;
   logic [23:0] cmd_addr;
   logic [1:0]  cmd_addr_bytes;
   logic [2:0]  cmd_dummy_bytes;
   logic [9:0]  cmd_len;
   sfl_kind_t   cmd_kind;
   logic [`SFL_PTR_W-1:0] rewrite_ptr;
   logic [47:0] mem_hdr;
   logic [7:0]  rq[$], wq[$];
   logic [47:0] hq[$], mq[$];
   int          num_errors = 0, compares = 0, seed = 85, n;

   sfl_host #(.EP_CYC(50), .P_CYC(20), .OTPP_CYC(10), .REWRITE_OP(RW_OP)) dut_u (
      .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_addr_bytes(cmd_addr_bytes),
      .cmd_dummy_bytes(cmd_dummy_bytes), .cmd_len(cmd_len), .cmd_kind(cmd_kind),
      .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
      .rd_valid(rd_valid), .busy(busy), .rewrite_ptr(rewrite_ptr), .sck(sck),
      .cs_n(cs_n), .mosi(mosi), .flash_rst_n(flash_rst_n), .miso(miso));
   sfl_mem_model mem_u (.sck(sck), .cs_n(cs_n), .mosi(mosi), .flash_rst_n(flash_rst_n),
      .miso(miso), .hdr(mem_hdr), .fault(mem_fault));

   task automatic check(input logic ok, input string m);
      compares++;
      if (ok !== 1'b1) begin
         $display("ERROR %0t: %s", $time, m);
         num_errors++;
      end
   endtask
   task automatic results();
      $display("errors %0d, compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // notes the expected header, data and reply, then holds the request until taken
   task automatic do_cmd(input logic [7:0] op, input logic [23:0] a, input logic [1:0] ab,
                         input logic [2:0] db, input logic [9:0] len, input sfl_kind_t k);
      logic [47:0] m;
      logic [47:0] e;
      logic [7:0]  d;
      e = {op, a, 16'h0};
      m = (ab == 2'd3) ? 48'hffffffff0000 : 48'hff0000000000;
      for (int i = 0; i < len; i++) begin
         d = 8'($random(seed));
         if (k == KIND_READ && op inside {RD_OPS}) rq.push_back(op ^ 8'(ab + db + i));
         else wq.push_back(d);
         if (!(op inside {RD_OPS}) && i < 2) e[15-8*i -: 8] = d;
         if (!(op inside {RD_OPS}) && i < 2) m[15-8*i -: 8] = 8'hff;
      end
      hq.push_back(e);
      mq.push_back(m);
      @(negedge clk);
      {cmd_op, cmd_addr, cmd_addr_bytes, cmd_dummy_bytes} = {op, a, ab, db};
      {cmd_len, cmd_kind, cmd_valid} = {len, k, 1'b1};
      @(posedge clk);
      while (cmd_ready !== 1'b1) @(posedge clk);
      @(negedge clk);
      cmd_valid = 1'b0;
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // every header the memory took in must match the oldest note
   always @(posedge cs_n) if (flash_rst_n === 1'b1) begin
      check(hq.size() > 0 && ((mem_hdr ^ hq[0]) & mq[0]) === 48'h0, "frame header");
      if (hq.size() > 0) void'(hq.pop_front());
      if (mq.size() > 0) void'(mq.pop_front());
   end
   always @(posedge clk) if (rst_n && rd_valid === 1'b1) begin
      check(rq.size() > 0 && rd_data === rq[0], "read byte");
      if (rq.size() > 0) void'(rq.pop_front());
   end
   always @(posedge clk) if (wr_ready === 1'b1 && wr_valid === 1'b1) wtake = 1'b1;
   // write bytes stall at random but an offered byte is never withdrawn
   always @(negedge clk) begin
      if (wtake) begin
         void'(wq.pop_front());
         wtake = 1'b0;
         wr_valid = 1'b0;
      end else if (!wr_valid && wq.size() > 0 && ($random(seed) & 1)) wr_valid = 1'b1;
      wr_data = (wq.size() > 0) ? wq[0] : 8'h00;
   end
   initial begin
      #3000000;
      check(1'b0, "watchdog expired");
      results();
   end

   initial begin
      {rst_n, cmd_valid, wr_valid, wtake, wr_data, cmd_op} = '0;
      {cmd_addr, cmd_addr_bytes, cmd_dummy_bytes, cmd_len} = '0;
      cmd_kind = KIND_READ;
      repeat (2) @(negedge clk);
      check(cs_n === 1'b1 && flash_rst_n === 1'b0 && busy === 1'b1, "reset levels");
      rst_n = 1'b1;
      n = 0;
      while (flash_rst_n !== 1'b1) begin
         @(negedge clk);
         n++;
      end
      check(n >= `SFL_RST_CYC, "memory reset too short");
      foreach (RD_OPS[i]) do_cmd(RD_OPS[i], 24'($random(seed)), 2'($random(seed)),
         3'($random(seed) & 3), 10'(1 + ($random(seed) & 3)), KIND_READ);
      // 32 counted writes, opcodes arbitrary; two refresh frames fall due
      for (int i = 0; i < 32; i++) begin
         if (i % 2) begin
            do_cmd(8'h84, 24'($random(seed)), 2'd3, 3'd0, 10'd2, KIND_READ);
            do_cmd(8'h88, 24'($random(seed)), 2'd3, 3'd0, 10'd0, KIND_PROG);
         end else do_cmd(8'h82, 24'($random(seed)), 2'd3, 3'd0, 10'd2, KIND_EP);
         if (i % 16 == 15) begin
            hq.push_back({RW_OP, 24'((i / 16) << `SFL_PAGE_SHIFT), 16'h0});
            mq.push_back(48'hffffffff0000);
         end
      end
      do_cmd(8'h9b, 24'($random(seed)), 2'd3, 3'd0, 10'd1, KIND_OTP);
      @(negedge clk);
      while (cmd_ready !== 1'b1) @(negedge clk);
      check(rewrite_ptr === 11'd2, "refresh pointer");
      check(hq.size() == 0 && rq.size() == 0 && wq.size() == 0, "frames missing");
      check(mem_fault === 1'b0, "select low at reset release");
      results();
   end
endmodule
`default_nettype wire
